// ===== i2c_port_control_one.sv
/*
  control/status register, shift buffer and slave byte engine of the two-wire port.
  assumes an apb master on mclk; serial_clock_pin and serial_data_pin arrive
  asynchronously and are open-drain lines resolved outside.
*/
// Added by the designer: the APB slave port and the address map.
// How it works
// RULE1: master write while bus busy sets collision
// RULE2: slave write during shifting sets collision
// RULE3: byte into full buffer sets overflow
// RULE4: enable hands pins to serial port
// RULE5: disable returns pins to gpio control
// RULE6: mode field selects slave or master modes
// RULE7: software never loads reload with 0-2
// RULE8: slave clock release low stretches clock
`default_nettype none
module i2c_port_control_one
  import i2c_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data_pin_in,
  input wire logic serial_clock_pin_in,
  input wire pin_drive_t gpio_drive,
  output pin_drive_t pin_drive,
  output logic irq
);

  ctl_state_t st_ff;
  ctl_state_t nxt_st;

  logic mapped;
  logic wr;
  logic rd;
  logic slave_mode;
  logic ss_int;
  logic master_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic buf_write;
  logic collide;
  logic [EV_N-1:0] ev;
  logic [7:0] ctrl_rd;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode; zero wait states, read data captured in the setup cycle
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_BUF) ||
                  (paddr == ADDR_RELOAD) || (paddr == ADDR_ISTS) ||
                  (paddr == ADDR_IMASK) || (paddr == ADDR_STAT);
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && penable && !pwrite && mapped;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_ff.rdata;
  assign pin_drive = st_ff.pins;
  assign irq = st_ff.irq;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign slave_mode = st_ff.en && ((st_ff.mode == MODE_SLV10_SS) ||     // [RULE6]
                      (st_ff.mode == MODE_SLV7_SS) || (st_ff.mode == MODE_SLV7));
  assign ss_int = (st_ff.mode == MODE_SLV10_SS) || (st_ff.mode == MODE_SLV7_SS); // [RULE6]
  assign master_mode = st_ff.en && (st_ff.mode == MODE_FW_MASTER);      // [RULE6]

  // line events from the second and third synchroniser stages only
  assign scl_rise = st_ff.scl_sy[1] && !st_ff.scl_sy[2];
  assign scl_fall = !st_ff.scl_sy[1] && st_ff.scl_sy[2];
  assign start_det = st_ff.scl_sy[1] && st_ff.scl_sy[2] &&
                     !st_ff.sda_sy[1] && st_ff.sda_sy[2];
  assign stop_det = st_ff.scl_sy[1] && st_ff.scl_sy[2] &&
                    st_ff.sda_sy[1] && !st_ff.sda_sy[2];
  assign byte_done = slave_mode && scl_rise && !st_ff.tx_act &&
                     (st_ff.bit_cnt == BIT_LAST);

  // a refused buffer write leaves the shift register untouched
  assign buf_write = wr && (paddr == ADDR_BUF);
  assign collide = buf_write && ((master_mode && st_ff.busy) ||         // [RULE1]
                                 (slave_mode && st_ff.tx_act));         // [RULE2]

  always_comb begin
    ev = '0;
    ev[EV_WRITE_COLLISION_FLAG] = collide;
    ev[EV_OVF] = byte_done && st_ff.full;
    ev[EV_RX] = byte_done && !st_ff.full;
    ev[EV_START] = slave_mode && ss_int && start_det;
    ev[EV_STOP] = slave_mode && ss_int && stop_det;
  end

  assign ctrl_rd = {st_ff.write_collision_flag, st_ff.ovf, st_ff.en, st_ff.clock_release_control, st_ff.mode};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_sy = {st_ff.scl_sy[1:0], serial_clock_pin_in};
    nxt_st.sda_sy = {st_ff.sda_sy[1:0], serial_data_pin_in};

    // bus activity tracking, seen in every mode
    if (start_det) begin
      nxt_st.busy = 1'b1;
      nxt_st.bit_cnt = '0;
    end else if (stop_det) begin
      nxt_st.busy = 1'b0;
      nxt_st.tx_act = 1'b0;
      nxt_st.bit_cnt = '0;
    end else if (slave_mode && scl_rise) begin
      if (!st_ff.tx_act) begin
        nxt_st.rx_sh = {st_ff.rx_sh[6:0], st_ff.sda_sy[1]};
      end
      if (st_ff.bit_cnt == BIT_ACK) begin
        nxt_st.bit_cnt = '0;
        nxt_st.tx_act = 1'b0;
      end else begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      end
    end else if (slave_mode && scl_fall && st_ff.tx_act &&
                 (st_ff.bit_cnt != '0) && (st_ff.bit_cnt < BIT_ACK)) begin
      nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b1};
    end

    // software side of the control register: flags only clear on a zero
    if (wr && (paddr == ADDR_CTRL)) begin
      nxt_st.write_collision_flag = st_ff.write_collision_flag && pwdata[BIT_WRITE_COLLISION_FLAG];
      nxt_st.ovf = st_ff.ovf && pwdata[BIT_OVF];
      nxt_st.en = pwdata[BIT_EN];
      nxt_st.clock_release_control = pwdata[BIT_CKP];
      nxt_st.mode = pwdata[3:0];
    end
    if (wr && (paddr == ADDR_RELOAD)) begin
      nxt_st.reload = pwdata[7:0];                                     // [RULE7]
    end
    if (wr && (paddr == ADDR_IMASK)) begin
      nxt_st.imask = pwdata[EV_N-1:0];
    end
    if (buf_write && !collide && (slave_mode || master_mode)) begin
      nxt_st.tx_sh = pwdata[7:0];
      nxt_st.tx_act = 1'b1;
    end
    if (rd && (paddr == ADDR_BUF)) begin
      nxt_st.full = 1'b0;
    end

    // hardware sets come last so that they win over a clear
    if (byte_done && !st_ff.full) begin
      nxt_st.rx_buf = {st_ff.rx_sh[6:0], st_ff.sda_sy[1]};
      nxt_st.full = 1'b1;
    end
    if (ev[EV_OVF]) begin
      nxt_st.ovf = 1'b1;                                               // [RULE3]
    end
    if (collide) begin
      nxt_st.write_collision_flag = 1'b1;                                              // [RULE1] [RULE2]
    end
    nxt_st.ists = st_ff.ists;
    if (wr && (paddr == ADDR_ISTS)) begin
      nxt_st.ists = st_ff.ists & ~pwdata[EV_N-1:0];
    end
    nxt_st.ists = nxt_st.ists | ev;
    nxt_st.irq = |(nxt_st.ists & nxt_st.imask);

    // pin ownership; data is only driven while shifting out a zero
    if (nxt_st.en) begin
      nxt_st.pins.sda_out = 1'b0;                                      // [RULE4]
      nxt_st.pins.scl_out = 1'b0;
      nxt_st.pins.sda_oe = slave_mode && nxt_st.tx_act &&
                           (nxt_st.bit_cnt < BIT_ACK) && !nxt_st.tx_sh[7];
      nxt_st.pins.scl_oe = slave_mode && !nxt_st.clock_release_control;                  // [RULE8]
    end else begin
      nxt_st.pins = gpio_drive;                                        // [RULE5]
    end

    // read data is prepared in the setup cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: nxt_st.rdata = {24'h000000, ctrl_rd};
        ADDR_BUF: nxt_st.rdata = {24'h000000, st_ff.rx_buf};
        ADDR_RELOAD: nxt_st.rdata = {24'h000000, st_ff.reload};
        ADDR_ISTS: nxt_st.rdata = {27'h0000000, st_ff.ists};
        ADDR_IMASK: nxt_st.rdata = {27'h0000000, st_ff.imask};
        ADDR_STAT: nxt_st.rdata = {27'h0000000, st_ff.scl_sy[1], st_ff.sda_sy[1],
                                   st_ff.busy, st_ff.tx_act, st_ff.full};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.scl_sy <= 3'h7;
      st_ff.sda_sy <= 3'h7;
      st_ff.ists <= EV_RESET;
      st_ff.imask <= EV_RESET;
      st_ff.reload <= RELOAD_RESET;
      {st_ff.write_collision_flag, st_ff.ovf, st_ff.en, st_ff.clock_release_control, st_ff.mode} <= CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_master_busy_write_collision_flag: assert property ( // [RULE1]
    (buf_write && master_mode && st_ff.busy) |=> st_ff.write_collision_flag && st_ff.ists[EV_WRITE_COLLISION_FLAG])
    else $error("master write on busy bus did not flag collision");

  chk_slave_tx_write_collision_flag: assert property ( // [RULE2]
    (buf_write && slave_mode && st_ff.tx_act) |=> st_ff.write_collision_flag && $stable(st_ff.tx_sh))
    else $error("slave write during shifting did not flag collision");

  chk_write_collision_flag_sticky: assert property ( // [RULE2]
    (st_ff.write_collision_flag && !(wr && (paddr == ADDR_CTRL))) |=> st_ff.write_collision_flag)
    else $error("collision flag dropped without software");

  chk_overflow_set: assert property ( // [RULE3]
    (byte_done && st_ff.full && !(rd && (paddr == ADDR_BUF))) |=>
      st_ff.ovf && st_ff.full && $stable(st_ff.rx_buf))
    else $error("overflow not flagged or buffer overwritten");

  chk_rx_capture: assert property ( // [RULE3]
    (byte_done && !st_ff.full) |=> st_ff.full && !$past(st_ff.ovf) == !st_ff.ovf)
    else $error("received byte not stored");

  chk_enable_pins: assert property ( // [RULE4]
    (st_ff.en && !st_ff.pins.sda_out && !st_ff.pins.scl_out) or !st_ff.en)
    else $error("enabled port drives a high level");

  chk_disable_gpio: assert property ( // [RULE5]
    (!nxt_st.en) |=> (pin_drive == $past(gpio_drive)))
    else $error("disabled port does not pass gpio drive");

  chk_mode_slave: assert property ( // [RULE6]
    (st_ff.en && st_ff.mode == MODE_SLV7) |-> slave_mode && !master_mode && !ss_int)
    else $error("mode decode wrong");

  chk_clock_stretch: assert property ( // [RULE8]
    (slave_mode && !st_ff.clock_release_control) |=> ##0 (!st_ff.en || st_ff.pins.scl_oe ||
      $past(wr && paddr == ADDR_CTRL)))
    else $error("slave did not hold clock low");

  chk_irq_level: assert property (
    ((st_ff.ists & st_ff.imask) != '0) |-> irq)
    else $error("interrupt missing for unmasked event");

  cov_byte_rx: cover property (byte_done ##1 st_ff.full);
  cov_overflow: cover property (byte_done && st_ff.full);
  cov_collision: cover property (collide);
  cov_stretch: cover property (st_ff.pins.scl_oe [*3]);

endmodule // i2c_port_control_one
`default_nettype wire

// ===== i2c_ctl_pkg.sv
/*
  constants, field layout and carrier types of the two-wire port control block.
  assumes a 32-bit apb master and a 100 mhz mclk.
*/
`default_nettype none
package i2c_ctl_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_BUF = 12'h004;
  localparam logic [11:0] ADDR_RELOAD = 12'h008;
  localparam logic [11:0] ADDR_ISTS = 12'h00c;
  localparam logic [11:0] ADDR_IMASK = 12'h010;
  localparam logic [11:0] ADDR_STAT = 12'h014;

  //////////////////////////////////////////////////////////////////////////////
  // control register fields and reset values
  localparam int BIT_WRITE_COLLISION_FLAG = 7;
  localparam int BIT_OVF = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_CKP = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;

  // mode field encodings
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;
  localparam logic [3:0] MODE_SLV7_SS = 4'he;
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;

  // event bits, same layout in status and mask
  localparam int EV_N = 5;
  localparam int EV_WRITE_COLLISION_FLAG = 0;
  localparam int EV_OVF = 1;
  localparam int EV_RX = 2;
  localparam int EV_START = 3;
  localparam int EV_STOP = 4;
  localparam logic [EV_N-1:0] EV_RESET = 5'h00;

  // bit counter: data bits 0..7, then acknowledge slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // open-drain pin drive: oe high pulls the line low
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } pin_drive_t;

  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_release_control;
    logic [3:0] mode;
    logic [7:0] rx_buf;
    logic full;
    logic [7:0] tx_sh;
    logic tx_act;
    logic [7:0] rx_sh;
    logic [3:0] bit_cnt;
    logic [7:0] reload;
    logic [EV_N-1:0] ists;
    logic [EV_N-1:0] imask;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic busy;
    pin_drive_t pins;
    logic [31:0] rdata;
    logic irq;
  } ctl_state_t;

endpackage
`default_nettype wire

// ===== i2c_bus_peer.sv
/*
  remote two-wire master: start, byte and stop at a 160 ns bit period.
  assumes the bench resolves both open-drain lines with pull-ups.
*/
`default_nettype none
module i2c_bus_peer (
  output var logic scl_low,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80;

  // released lines rest high, so the clock stands still between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic clock_pulse;
    #(HALF / 2);
    scl_low = 1'b0;
    #(HALF);
    scl_low = 1'b1;
    #(HALF / 2);
  endtask

  task automatic start_bit;
    sda_low = 1'b1;
    #(HALF);
    scl_low = 1'b1;
    #(HALF);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      // msb first; data moves only while the clock is low
      sda_low = ~b[i];
      clock_pulse();
    end
    sda_low = 1'b0;
    clock_pulse();
  endtask

  task automatic stop_bit;
    sda_low = 1'b1;
    #(HALF / 2);
    scl_low = 1'b0;
    #(HALF);
    sda_low = 1'b0;
    #(HALF);
  endtask
endmodule // i2c_bus_peer
`default_nettype wire

// ===== i2c_port_control_one_tb_top.sv
/*
  self-checking bench of the two-wire port control block.
  assumes the bus peer model and the zero wait state apb slave of the design.
*/
`default_nettype none
module i2c_port_control_one_tb_top;
  import i2c_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pin_drive_t gpio_drive, pin_drive;
  wire logic scl_low, sda_low;
  wire logic scl_line = ~((pin_drive.scl_oe & ~pin_drive.scl_out) | scl_low);
  wire logic sda_line = ~((pin_drive.sda_oe & ~pin_drive.sda_out) | sda_low);
  int err_count, checks;
  logic [3:0] modes [4] = '{MODE_SLV10_SS, MODE_SLV7_SS, MODE_SLV7, MODE_FW_MASTER};

  i2c_port_control_one i2c_port_control_one_inst (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_data_pin_in(sda_line),
    .serial_clock_pin_in(scl_line), .gpio_drive(gpio_drive),
    .pin_drive(pin_drive), .irq(irq));
  i2c_bus_peer i2c_bus_peer_inst (.scl_low(scl_low), .sda_low(sda_low));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one transfer; the request holds until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: no pready", $time);
      final_report();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpio_drive = 4'h5;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_ISTS, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, slv}, 32'h1, "unmapped");
    chk({28'h0, pin_drive}, {28'h0, gpio_drive}, "gpio pins");
    apb(1'b1, ADDR_CTRL, 32'h36);
    repeat (4) @(posedge mclk);
    chk({28'h0, pin_drive}, 32'h0, "port pins");
    foreach (modes[i]) begin
      apb(1'b1, ADDR_CTRL, {24'h0, 4'h3, modes[i]});
      rdchk(ADDR_CTRL, {24'h0, 4'h3, modes[i]});
    end
    apb(1'b1, ADDR_RELOAD, 32'h03);
    rdchk(ADDR_RELOAD, 32'h03);
    // two bytes with no read between them
    apb(1'b1, ADDR_CTRL, 32'h36);
    apb(1'b1, ADDR_IMASK, 32'h02);
    i2c_bus_peer_inst.start_bit();
    i2c_bus_peer_inst.send_byte(8'h5a);
    i2c_bus_peer_inst.send_byte(8'ha5);
    i2c_bus_peer_inst.stop_bit();
    repeat (8) @(posedge mclk);
    rdchk(ADDR_CTRL, 32'h76);
    rdchk(ADDR_ISTS, 32'h06);
    chk({31'h0, irq}, 32'h1, "irq set");
    rdchk(ADDR_BUF, 32'h5a);
    apb(1'b1, ADDR_IMASK, 32'h00);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, ADDR_CTRL, 32'h36);
    apb(1'b1, ADDR_ISTS, 32'h1f);
    rdchk(ADDR_ISTS, 32'h00);
    // start and stop events only raise status in the start/stop slave modes
    apb(1'b1, ADDR_CTRL, 32'h3e);
    i2c_bus_peer_inst.start_bit();
    i2c_bus_peer_inst.stop_bit();
    repeat (8) @(posedge mclk);
    rdchk(ADDR_ISTS, 32'h18);
    apb(1'b1, ADDR_CTRL, 32'h36);
    // second buffer write while the first word is still shifting
    apb(1'b1, ADDR_BUF, 32'h3c);
    apb(1'b1, ADDR_BUF, 32'hc3);
    rdchk(ADDR_CTRL, 32'hb6);
    apb(1'b1, ADDR_CTRL, 32'h36);
    rdchk(ADDR_CTRL, 32'h36);
    apb(1'b1, ADDR_CTRL, 32'h26);
    repeat (4) @(posedge mclk);
    chk({31'h0, pin_drive.scl_oe}, 32'h1, "stretch");
    // master write while another master holds the bus
    apb(1'b1, ADDR_CTRL, 32'h3b);
    i2c_bus_peer_inst.start_bit();
    repeat (4) @(posedge mclk);
    apb(1'b1, ADDR_BUF, 32'h55);
    rdchk(ADDR_CTRL, 32'hbb);
    i2c_bus_peer_inst.stop_bit();
    apb(1'b1, ADDR_CTRL, 32'h00);
    repeat (4) @(posedge mclk);
    chk({28'h0, pin_drive}, {28'h0, gpio_drive}, "pins back");
    final_report();
  end
endmodule // i2c_port_control_one_tb_top
`default_nettype wire
